/* File: rtl/llm_map.svh */
// Constants for the line loss and lock monitor
`ifndef LLM_MAP_SVH
`define LLM_MAP_SVH

// ----------------------------------------------------------------
// Lock window and tolerance
// ----------------------------------------------------------------
`define LLM_REF_WINDOW 1024
`define LLM_VCO_RATIO  8
`define LLM_TOL_PPM    500
`define LLM_PPM_SCALE  1000000

// ----------------------------------------------------------------
// Synchroniser bit positions
// ----------------------------------------------------------------
`define LLM_SYNC_W     7
`define LLM_B_SEL      0
`define LLM_B_CP       1
`define LLM_B_CR       2
`define LLM_B_PP       3
`define LLM_B_PR       4
`define LLM_B_VCO      5
`define LLM_B_REF      6

`endif

/* File: rtl/llm_pkg.sv */
// Types for the line loss and lock monitor
`default_nettype none
package llm_pkg;
    typedef enum logic {
        LLM_PORT_PRIMARY,
        LLM_PORT_REDUNDANT
    } llm_port_e;
endpackage
`default_nettype wire

/* File: rtl/llm_freq_if.sv */
// Carrier between the monitor and its frequency comparator
`timescale 1ns/1ps
`default_nettype none
interface llm_freq_if;
    logic vco_edge;
    logic ref_edge;
    logic win_done;
    logic in_tol;
    modport cmp (input vco_edge, input ref_edge, output win_done, output in_tol);
    modport mon (output vco_edge, output ref_edge, input win_done, input in_tol);
endinterface
`default_nettype wire

/* File: rtl/llm_freq_cmp.sv */
// Recovery oscillator against reference frequency comparator
`timescale 1ns/1ps
`default_nettype none
`include "llm_map.svh"
module llm_freq_cmp #(
    parameter int REF_WIN   = `LLM_REF_WINDOW,
    parameter int VCO_RATIO = `LLM_VCO_RATIO,
    parameter int TOL_PPM   = `LLM_TOL_PPM
) (
    input wire logic  clock,
    input wire logic  rst_n,
    llm_freq_if.cmp   fif
);
    localparam int EXPECT = REF_WIN * VCO_RATIO;
    localparam int TOL_RAW = (EXPECT * TOL_PPM) / `LLM_PPM_SCALE;
    // A zero band would never lock on a real oscillator
    localparam int TOL = (TOL_RAW < 1) ? 1 : TOL_RAW;
    localparam int CW  = $clog2(2 * EXPECT + 1) + 1;
    localparam int RW  = $clog2(REF_WIN) + 1;

    logic [RW-1:0] ref_cnt_r;
    logic [CW-1:0] vco_cnt_r;
    logic          done_r;
    logic          in_tol_r;

    function automatic logic within_tol(input logic [CW-1:0] n);
        logic [CW-1:0] e;
        logic [CW-1:0] d;
        e = CW'(EXPECT);
        d = (n > e) ? n - e : e - n;
        return d <= CW'(TOL);
    endfunction

    wire           win_end = fif.ref_edge && (ref_cnt_r == RW'(REF_WIN - 1));
    wire           vco_sat = &vco_cnt_r;
    wire  [CW-1:0] vco_sum = vco_cnt_r + CW'(fif.vco_edge && !vco_sat);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ref_cnt_r <= '0;
            vco_cnt_r <= '0;
            done_r    <= 1'b0;
            in_tol_r  <= 1'b0;
        end else if (win_end) begin
            ref_cnt_r <= '0;
            vco_cnt_r <= '0;
            done_r    <= 1'b1;
            in_tol_r  <= within_tol(vco_sum);
        end else begin
            ref_cnt_r <= ref_cnt_r + RW'(fif.ref_edge);
            vco_cnt_r <= vco_sum;
            done_r    <= 1'b0;
        end
    end

    assign fif.win_done = done_r;
    assign fif.in_tol   = in_tol_r;
endmodule // llm_freq_cmp
`default_nettype wire

/* File: rtl/llm_monitor.sv */
// Line loss, PECL loss and clock recovery lock monitor
`timescale 1ns/1ps
`default_nettype none
`include "llm_map.svh"
module llm_monitor #(
    parameter int REF_WIN   = `LLM_REF_WINDOW,
    parameter int VCO_RATIO = `LLM_VCO_RATIO,
    parameter int TOL_PPM   = `LLM_TOL_PPM
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic port_select_redundant,
    input  wire logic carrier_loss_in_primary,
    input  wire logic carrier_loss_in_redundant,
    input  wire logic pecl_loss_in_primary,
    input  wire logic pecl_loss_in_redundant,
    input  wire logic vco_div_in,
    input  wire logic ref_div_in,
    output logic      active_port_redundant,
    output logic      optical_carrier_lost,
    output logic      pecl_interface_lost,
    output logic      carrier_lost_event,
    output logic      cdr_lock_indicator,
    output logic      lock_lost_event
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [`LLM_SYNC_W-1:0] sync1_r;
    logic [`LLM_SYNC_W-1:0] sync2_r;
    logic                   vco_prev_r;
    logic                   ref_prev_r;

    wire [`LLM_SYNC_W-1:0] pins_in = {ref_div_in, vco_div_in, pecl_loss_in_redundant,
                                      pecl_loss_in_primary, carrier_loss_in_redundant,
                                      carrier_loss_in_primary, port_select_redundant};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_r    <= '0;
            sync2_r    <= '0;
            vco_prev_r <= 1'b0;
            ref_prev_r <= 1'b0;
        end else begin
            sync1_r    <= pins_in;
            sync2_r    <= sync1_r;
            vco_prev_r <= sync2_r[`LLM_B_VCO];
            ref_prev_r <= sync2_r[`LLM_B_REF];
        end
    end

    // ----------------------------------------------------------------
    // Port steering and alarm decode
    // ----------------------------------------------------------------
    llm_pkg::llm_port_e port_s;
    assign port_s = sync2_r[`LLM_B_SEL] ? llm_pkg::LLM_PORT_REDUNDANT
                                        : llm_pkg::LLM_PORT_PRIMARY;

    wire sel_s = sync2_r[`LLM_B_SEL];
    wire cp_s  = sync2_r[`LLM_B_CP];
    wire cr_s  = sync2_r[`LLM_B_CR];
    wire pp_s  = sync2_r[`LLM_B_PP];
    wire pr_s  = sync2_r[`LLM_B_PR];

    // Only the active port's pair reaches the decode
    wire act_carrier = (port_s == llm_pkg::LLM_PORT_REDUNDANT) ? cr_s : cp_s;
    wire act_pecl    = (port_s == llm_pkg::LLM_PORT_REDUNDANT) ? pr_s : pp_s;

    // Matching levels mean loss; a healthy module drives them apart
    wire loc_nxt  = ~(act_carrier ^ act_pecl);
    wire lopi_nxt = act_pecl;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            active_port_redundant <= 1'b0;
            optical_carrier_lost  <= 1'b0;
            pecl_interface_lost   <= 1'b0;
            carrier_lost_event    <= 1'b0;
        end else begin
            active_port_redundant <= sel_s;
            optical_carrier_lost  <= loc_nxt;
            pecl_interface_lost   <= lopi_nxt;
            carrier_lost_event    <= loc_nxt && !optical_carrier_lost;
        end
    end

    // ----------------------------------------------------------------
    // Lock detection
    // ----------------------------------------------------------------
    llm_freq_if fif ();

    assign fif.vco_edge = sync2_r[`LLM_B_VCO] ^ vco_prev_r;
    assign fif.ref_edge = sync2_r[`LLM_B_REF] ^ ref_prev_r;

    llm_freq_cmp #(
        .REF_WIN   (REF_WIN),
        .VCO_RATIO (VCO_RATIO),
        .TOL_PPM   (TOL_PPM)
    ) u_cmp (
        .clock (clock),
        .rst_n (rst_n),
        .fif   (fif.cmp)
    );

    // Lock only moves at window ends, so a single slow window drops it
    wire lock_nxt = fif.win_done ? fif.in_tol : cdr_lock_indicator;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cdr_lock_indicator <= 1'b0;
            lock_lost_event    <= 1'b0;
        end else begin
            cdr_lock_indicator <= lock_nxt;
            lock_lost_event    <= fif.win_done && !fif.in_tol && cdr_lock_indicator;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_prim_match;
        !sel_s && (cp_s == pp_s);
    endsequence

    sequence s_red_match;
        sel_s && (cr_s == pr_s);
    endsequence

    // The cycle before must be out of reset, else the alarms still show reset values
    sequence s_red_held;
        sel_s && $stable(sel_s) && $stable(cr_s) && $stable(pr_s) && $past(rst_n);
    endsequence

    sequence s_prim_held;
        !sel_s && $stable(sel_s) && $stable(cp_s) && $stable(pp_s) && $past(rst_n);
    endsequence

    property p_loc_primary;
        s_prim_match |=> optical_carrier_lost;
    endproperty
    a_loc_primary: assert property (p_loc_primary)
        else $error("carrier loss missed on primary port");

    property p_loc_redundant;
        s_red_match |=> optical_carrier_lost;
    endproperty
    a_loc_redundant: assert property (p_loc_redundant)
        else $error("carrier loss missed on redundant port");

    property p_lopi_primary;
        !sel_s |=> (pecl_interface_lost == $past(pp_s));
    endproperty
    a_lopi_primary: assert property (p_lopi_primary)
        else $error("PECL loss wrong on primary port");

    property p_lopi_redundant;
        sel_s |=> (pecl_interface_lost == $past(pr_s));
    endproperty
    a_lopi_redundant: assert property (p_lopi_redundant)
        else $error("PECL loss wrong on redundant port");

    property p_ignore_primary;
        s_red_held |=> $stable(optical_carrier_lost) && $stable(pecl_interface_lost);
    endproperty
    a_ignore_primary: assert property (p_ignore_primary)
        else $error("primary inputs moved alarms while redundant active");

    property p_ignore_redundant;
        s_prim_held |=> $stable(optical_carrier_lost) && $stable(pecl_interface_lost);
    endproperty
    a_ignore_redundant: assert property (p_ignore_redundant)
        else $error("redundant inputs moved alarms while primary active");

    property p_lock_gain;
        fif.win_done && fif.in_tol |=> cdr_lock_indicator;
    endproperty
    a_lock_gain: assert property (p_lock_gain)
        else $error("lock not raised after in-tolerance window");

    property p_lock_hold;
        !fif.win_done |=> $stable(cdr_lock_indicator);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lock moved between windows");

    property p_lock_loss;
        fif.win_done && !fif.in_tol && cdr_lock_indicator
            |=> !cdr_lock_indicator && lock_lost_event ##1 !lock_lost_event;
    endproperty
    a_lock_loss: assert property (p_lock_loss)
        else $error("loss of lock not declared");

    property p_port_follow;
        ##1 1'b1 |-> active_port_redundant == $past(sel_s);
    endproperty
    a_port_follow: assert property (p_port_follow)
        else $error("active port indication wrong");

    property p_loc_event;
        carrier_lost_event |-> optical_carrier_lost && !$past(optical_carrier_lost);
    endproperty
    a_loc_event: assert property (p_loc_event)
        else $error("carrier loss event without rising alarm");

    property p_lock_event;
        lock_lost_event |-> !cdr_lock_indicator && $past(cdr_lock_indicator);
    endproperty
    a_lock_event: assert property (p_lock_event)
        else $error("lock loss event without falling lock");
endmodule // llm_monitor
`default_nettype wire

/* File: test/llm_xcvr_model.sv */
// Optical transceiver model driving the loss outputs of one port
`timescale 1ns/1ps
`default_nettype none
module llm_xcvr_model (
    input  wire logic clock,
    input  wire logic dark,
    input  wire logic pecl_fault,
    output logic      carrier_loss,
    output logic      pecl_loss
);
    // Outputs move one edge after the optics change, like a real module
    always_ff @(posedge clock) begin
        carrier_loss <= dark;
        pecl_loss    <= pecl_fault;
    end
endmodule // llm_xcvr_model
`default_nettype wire

/* File: test/test_line_loss_and_lock_monitor.sv */
// Self-checking bench for the line loss and lock monitor
`timescale 1ns/1ps
`default_nettype none
module test_line_loss_and_lock_monitor;
    localparam int RW   = 16;
    localparam int VR   = 8;
    localparam int TP   = 500;
    localparam int EXP  = RW * VR;
    localparam int TOLT = (EXP * TP / 1000000 > 1) ? EXP * TP / 1000000 : 1;
    logic clock, rst_n, sel, dark_p, dark_r, pf_p, pf_r, vco, refc;
    logic cl_p, cl_r, pl_p, pl_r, actv, ocl, pil, cle, lock, lle;
    int   fails, cmp_count, ce_n, le_n;
    // ----------------------------------------------------------------
    // Far side and device
    // ----------------------------------------------------------------
    // Each transceiver's carrier-loss output feeds its own port
    llm_xcvr_model u_xp (.clock(clock), .dark(dark_p), .pecl_fault(pf_p),
                         .carrier_loss(cl_p), .pecl_loss(pl_p));
    llm_xcvr_model u_xr (.clock(clock), .dark(dark_r), .pecl_fault(pf_r),
                         .carrier_loss(cl_r), .pecl_loss(pl_r));
    llm_monitor #(.REF_WIN(RW), .VCO_RATIO(VR), .TOL_PPM(TP)) u_dut (
        .clock(clock), .rst_n(rst_n), .port_select_redundant(sel),
        .carrier_loss_in_primary(cl_p), .carrier_loss_in_redundant(cl_r),
        .pecl_loss_in_primary(pl_p), .pecl_loss_in_redundant(pl_r),
        .vco_div_in(vco), .ref_div_in(refc), .active_port_redundant(actv),
        .optical_carrier_lost(ocl), .pecl_interface_lost(pil),
        .carrier_lost_event(cle), .cdr_lock_indicator(lock),
        .lock_lost_event(lle));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Pulse counters for the one-cycle event outputs
    always @(posedge clock) begin
        if (cle === 1'b1) ce_n++;
        if (lle === 1'b1) le_n++;
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic seen, input logic exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t %s seen %b want %b", $time, what, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic set_pins(input logic [4:0] v);
        @(posedge clock);
        sel    <= v[0];
        dark_p <= v[1];
        pf_p   <= v[2];
        dark_r <= v[3];
        pf_r   <= v[4];
    endtask
    // Ticks spread evenly over the window, never closer than two cycles
    task automatic window(input int n);
        for (int r = 0; r < RW; r++) begin
            repeat (n / RW + ((r < n % RW) ? 1 : 0)) begin
                @(posedge clock);
                vco <= ~vco;
                @(posedge clock);
            end
            @(posedge clock);
            refc <= ~refc;
            @(posedge clock);
        end
        cyc(5);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_alarm_table;
        logic [4:0] v;
        logic       ec, ep;
        for (int i = 0; i < 32; i++) begin
            v = i[4:0];
            set_pins(v);
            cyc(6);
            ec = v[0] ? ~(v[3] ^ v[4]) : ~(v[1] ^ v[2]);
            ep = v[0] ? v[4] : v[2];
            check(actv, v[0], "active port");
            check(ocl, ec, "carrier lost");
            check(pil, ep, "pecl lost");
        end
        $display("test alarm table done");
    endtask
    // Active port stays healthy while the idle port walks every level pair
    task automatic test_port_isolation;
        logic [4:0] v;
        for (int i = 0; i < 8; i++) begin
            v = i[2] ? {2'b01, i[1:0], 1'b1} : {i[1:0], 2'b01, 1'b0};
            set_pins(v);
            cyc(6);
            check(actv, i[2], "isolation port");
            check(ocl, 1'b0, "idle port moved carrier alarm");
            check(pil, 1'b0, "idle port moved pecl alarm");
        end
        $display("test port isolation done");
    endtask
    task automatic test_carrier_event;
        set_pins(5'h02);
        cyc(6);
        check(ocl, 1'b0, "carrier present");
        ce_n = 0;
        set_pins(5'h06);
        cyc(8);
        check(ocl, 1'b1, "carrier lost");
        check(ce_n == 1, 1'b1, "one event pulse");
        $display("test carrier event done");
    endtask
    task automatic test_lock;
        window(EXP);
        window(EXP);
        check(lock, 1'b1, "lock exact");
        le_n = 0;
        window(EXP + TOLT + 1);
        check(lock, 1'b0, "lock fast");
        check(le_n == 1, 1'b1, "lock lost pulse");
        window(EXP - TOLT);
        check(lock, 1'b1, "lock low edge");
        window(EXP - TOLT - 1);
        check(lock, 1'b0, "lock slow");
        window(EXP + TOLT);
        check(lock, 1'b1, "lock high edge");
        check(le_n == 2, 1'b1, "lock lost count");
        $display("test lock done");
    endtask
    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Whole run needs under 4000 cycles; the limit leaves ample margin
    initial begin
        cyc(20000);
        fails++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        {sel, dark_p, dark_r, pf_p, pf_r, vco, refc} = 7'h00;
        fails = 0;
        cmp_count = 0;
        ce_n = 0;
        le_n = 0;
        cyc(2);
        rst_n <= 1'b1;
        test_alarm_table();
        test_port_isolation();
        test_carrier_event();
        test_lock();
        conclude();
    end
endmodule // test_line_loss_and_lock_monitor
`default_nettype wire
